/* cpt_pkg.sv */
/*
 * Package for the charger protection timer block: timing constants,
 * field widths, state encodings and reset values.
 * Assumes a 50 MHz core clock; times are held in their own unit and
 * converted to cycles here.
 */
package cpt_pkg;
    localparam int unsigned CLK_HZ         = 50_000_000;
    // timing in printed units
    localparam int unsigned FET_ON_US      = 5000;  // 5 ms input FET on window
    localparam int unsigned FET_OFF_US     = 200;   // 200 us off between retries
    localparam int unsigned RETRY_CLR_MS   = 2000;  // 2 s retry counter refresh
    localparam int unsigned INT_PULSE_US   = 128;   // interrupt low pulse
    // cycle counts (exact at 50 MHz, no rounding)
    localparam int unsigned FET_ON_CYC     = (FET_ON_US * (CLK_HZ / 1_000_000));
    localparam int unsigned FET_OFF_CYC    = (FET_OFF_US * (CLK_HZ / 1_000_000));
    localparam int unsigned RETRY_CLR_CYC  = (RETRY_CLR_MS * (CLK_HZ / 1_000));
    localparam int unsigned INT_PULSE_CYC  = (INT_PULSE_US * (CLK_HZ / 1_000_000));
    localparam logic [3:0]  SHORT_TRIES    = 4'hA;
    // safety timer tick = 1 s in default cycles (parameter in top)
    localparam int unsigned TICK_CYC       = CLK_HZ;
    // safety timer durations in ticks, index = 2-bit field
    localparam logic [15:0] FAST_LIM_0     = 16'h0_E10;  // 1 h in s
    localparam logic [15:0] FAST_LIM_1     = 16'h1_C20;  // 2 h
    localparam logic [15:0] FAST_LIM_2     = 16'h2_A30;  // 3 h
    localparam logic [15:0] FAST_LIM_3     = 16'h0_000;  // disabled
    // watchdog periods in ticks, index = 2-bit field
    localparam logic [15:0] WD_LIM_0       = 16'h0_032;  // 50 s
    localparam logic [15:0] WD_LIM_1       = 16'h0_064;  // 100 s
    localparam logic [15:0] WD_LIM_2       = 16'h0_0A0;  // 160 s
    localparam logic [15:0] WD_LIM_3       = 16'h0_000;  // disabled
    localparam logic [1:0]  SAFETY_SEL_RST = 2'h1;
    localparam logic [1:0]  WD_SEL_RST     = 2'h0;
    localparam logic [1:0]  DIE_REGULATION_TEMPERATURE_SEL_RST   = 2'h0;
    localparam logic        DOUBLE_RST     = 1'h1;
    localparam logic        CHG_EN_RST     = 1'h1;

    // system short supervisor
    typedef enum logic [2:0] {
        SS_IDLE  = 3'b000,
        SS_ON    = 3'b001,
        SS_OFF   = 3'b010,
        SS_OK    = 3'b011,
        SS_LOCK  = 3'b100
    } cpt_short_e;

    // charge phase seen by the safety timer
    typedef enum logic [1:0] {
        PH_NONE  = 2'b00,
        PH_PRE   = 2'b01,
        PH_FAST  = 2'b10
    } cpt_phase_e;
endpackage : cpt_pkg

/* cpt_top.sv */
/*
 * Protection and supervisory timers of a single-cell linear charger:
 * system overvoltage cutoff, system short retries, thermal shutdown and
 * regulation, safety timers and the host watchdog.
 * Assumes analog comparator flags arrive asynchronously and are
 * synchronised here; host transaction pulses arrive on the serial link
 * clock and are carried over by toggle.
 */
`timescale 1ns/1ps
module cpt_top #(
    parameter int unsigned TICK_CYCLES  = cpt_pkg::TICK_CYC,
    parameter int unsigned RETRY_CYCLES = cpt_pkg::RETRY_CLR_CYC,
    parameter int unsigned ON_CYCLES    = cpt_pkg::FET_ON_CYC
) (
    // core clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // serial link clock and reset, transaction strobe on that clock
    input  wire logic       link_clk,
    input  wire logic       link_rstn,
    input  wire logic       link_xact,
    // host settings written over the link
    input  wire logic       set_we,
    input  wire logic [1:0] set_safety_sel,
    input  wire logic [1:0] set_wd_sel,
    input  wire logic [1:0] set_die_regulation_temperature_sel,
    input  wire logic       set_double,
    input  wire logic       set_chg_en,
    input  wire logic       set_wd_en,
    // analog comparator flags (asynchronous)
    input  wire logic       adapter_ok,
    input  wire logic       sys_above_guard,
    input  wire logic       sys_below_release,
    input  wire logic       sys_below_short,
    input  wire logic       die_above_shutdown,
    input  wire logic       die_below_shutdown_fall,
    input  wire logic [3:0] die_above_die_regulation_temperature,
    input  wire logic       battery_present,
    // charger loop states (asynchronous)
    input  wire logic       in_precharge,
    input  wire logic       in_fast,
    input  wire logic       charge_done,
    input  wire logic       dpm_active,
    input  wire logic       ntc_limit,
    input  wire logic       battery_cool_region,
    input  wire logic       supplement,
    // switch controls
    output logic            input_fet_on,
    output logic            battery_path_switch_on,
    output logic            sys_enable,
    output logic            charge_allow,
    output logic            current_reduce,
    // status to host
    output logic            charge_timeout_fault_flag,
    output logic            int_n_oe,
    output logic            wd_reset_pulse,
    output logic [1:0]      safety_sel,
    output logic [1:0]      wd_sel,
    output logic [1:0]      die_regulation_temperature_sel,
    output logic            timeout_doubling_enable,
    output logic            chg_en,
    output logic            wd_en
);
    import cpt_pkg::*;

    localparam int NS = 18; // synchronised async inputs

    // link side: transaction toggle and settings hold, one domain only
    logic       lk_tog_q;
    logic       lk_wtog_q;
    logic [9:0] lk_set_q;
    always_ff @(posedge link_clk) begin
        if (!link_rstn) begin
            lk_tog_q  <= 1'b0;
            lk_wtog_q <= 1'b0;
            lk_set_q  <= 10'h000;
        end else begin
            if (link_xact) lk_tog_q <= ~lk_tog_q;
            if (set_we) begin
                lk_wtog_q <= ~lk_wtog_q;
                lk_set_q  <= {set_safety_sel, set_wd_sel, set_die_regulation_temperature_sel,
                              set_double, set_chg_en, set_wd_en, 1'b0};
            end
        end
    end

    // core state
    typedef struct packed {
        logic [NS-1:0] s1, s2;
        logic [2:0]    xt, wt;      // toggle syncs plus edge stage
        logic [9:0]    sh1, sh2;    // settings word, stable after toggle
        cpt_short_e    ss;
        logic [27:0]   st_cnt;
        logic [3:0]    tries;
        logic [31:0]   rcnt;
        logic          adp_q;
        logic          hot_lock;
        cpt_phase_e    ph;
        logic          pre_seen;
        logic [27:0]   tick;
        logic          half;
        logic [15:0]   safe;
        logic          expired;
        logic [12:0]   ipulse;
        logic          wd_run;
        logic [27:0]   wtick;
        logic [15:0]   wsec;
        logic          wd_rst;
        logic [1:0]    ssel, wsel, tsel;
        logic          dbl, cen, wen;
        logic          ovp;
        logic          in_on, bat_on, sys_on, chg, red, flag, ioe;
    } cpt_state_s;
    cpt_state_s q, d;

    logic [NS-1:0] raw;
    assign raw = {adapter_ok, sys_above_guard, sys_below_release, sys_below_short,
                  die_above_shutdown, die_below_shutdown_fall, die_above_die_regulation_temperature,
                  battery_present, in_precharge, in_fast, charge_done, dpm_active,
                  ntc_limit, battery_cool_region, supplement};

    // synced views
    logic adp, ovr, rel, shrt, hot, cool, bat, pre, fst, done, dpm, ntc, cld, sup;
    logic [3:0] die_regulation_temperature_hit;
    assign {adp, ovr, rel, shrt, hot, cool, die_regulation_temperature_hit, bat, pre, fst, done, dpm,
            ntc, cld, sup} = q.s2;

    function automatic logic [15:0] fast_lim(input logic [1:0] s);
        case (s)
            2'd0:    fast_lim = FAST_LIM_0;
            2'd1:    fast_lim = FAST_LIM_1;
            2'd2:    fast_lim = FAST_LIM_2;
            default: fast_lim = FAST_LIM_3;
        endcase
    endfunction : fast_lim

    function automatic logic [15:0] wd_lim(input logic [1:0] s);
        case (s)
            2'd0:    wd_lim = WD_LIM_0;
            2'd1:    wd_lim = WD_LIM_1;
            2'd2:    wd_lim = WD_LIM_2;
            default: wd_lim = WD_LIM_3;
        endcase
    endfunction : wd_lim

    logic [15:0] lim;
    logic        xact_ev, set_ev, adp_rise, new_sel, run, slow;

    always_comb begin
        d = q;
        // two-stage synchronisers; stage one feeds stage two only
        d.s1  = raw;
        d.s2  = q.s1;
        d.xt  = {q.xt[1:0], lk_tog_q};
        d.wt  = {q.wt[1:0], lk_wtog_q};
        d.sh1 = lk_set_q;
        d.sh2 = q.sh1;
        xact_ev  = q.xt[2] ^ q.xt[1];
        set_ev   = q.wt[2] ^ q.wt[1];
        adp_rise = adp & ~q.adp_q;
        d.adp_q  = adp;
        d.wd_rst = 1'b0;
        new_sel  = 1'b0;

        // host settings; settings word has been stable two cycles
        if (set_ev) begin
            new_sel = (q.sh2[9:8] != q.ssel);
            d.ssel = q.sh2[9:8];
            d.wsel = q.sh2[7:6];
            d.tsel = q.sh2[5:4];
            d.dbl  = q.sh2[3];
            d.cen  = q.sh2[2];
            d.wen  = q.sh2[1];
        end

        // watchdog: armed by first transaction, restarted by each
        if (xact_ev) begin
            d.wd_run = q.wen;
            d.wtick  = '0;
            d.wsec   = '0;
        end else if (q.wd_run && q.wen && wd_lim(q.wsel) != 16'h0_000) begin
            if (q.wtick == 28'(TICK_CYCLES - 1)) begin
                d.wtick = '0;
                d.wsec  = q.wsec + 16'h0_001;
                if (q.wsec + 16'h0_001 >= wd_lim(q.wsel)) begin
                    // expiry: settings back to defaults, watchdog idles
                    d.ssel = SAFETY_SEL_RST;
                    d.wsel = WD_SEL_RST;
                    d.tsel = DIE_REGULATION_TEMPERATURE_SEL_RST;
                    d.dbl  = DOUBLE_RST;
                    d.cen  = CHG_EN_RST;
                    d.wen  = 1'b1;
                    d.wd_run = 1'b0;
                    d.wd_rst = 1'b1;
                    new_sel  = (q.ssel != SAFETY_SEL_RST);
                end
            end else begin
                d.wtick = q.wtick + 28'h000_0001;
            end
        end

        // system overvoltage with hysteresis
        if (ovr) d.ovp = 1'b1;
        else if (rel) d.ovp = 1'b0;

        // thermal: hot at any time, including power-up, holds paths off
        if (hot) d.hot_lock = 1'b1;
        else if (cool && (adp || bat)) d.hot_lock = 1'b0;

        // system short supervisor
        d.rcnt = (q.rcnt >= 32'(RETRY_CYCLES - 1)) ? '0 : q.rcnt + 32'h0000_0001;
        case (q.ss)
            SS_IDLE: begin
                d.tries = '0;
                if (adp) begin
                    d.ss = SS_ON;
                    d.st_cnt = '0;
                end
            end
            SS_ON: begin
                d.st_cnt = q.st_cnt + 28'h000_0001;
                if (q.st_cnt == 28'(ON_CYCLES - 1)) begin
                    d.st_cnt = '0;
                    if (!shrt) d.ss = SS_OK;
                    else if (q.tries == SHORT_TRIES - 4'h1) d.ss = SS_LOCK;
                    else begin
                        d.ss = SS_OFF;
                        d.tries = q.tries + 4'h1;
                    end
                end
            end
            SS_OFF: begin
                d.st_cnt = q.st_cnt + 28'h000_0001;
                if (q.st_cnt == 28'(FET_OFF_CYC - 1)) begin
                    d.st_cnt = '0;
                    d.ss = SS_ON;
                end
            end
            SS_OK: begin
                if (q.rcnt == '0) d.tries = '0;
                if (shrt) begin
                    d.ss = SS_OFF;
                    d.st_cnt = '0;
                end
            end
            SS_LOCK: begin
                // waits out the 2 s refresh, then tries ten more times
                if (q.rcnt == '0) begin
                    d.tries = '0;
                    d.ss = SS_ON;
                    d.st_cnt = '0;
                end
            end
            default: d.ss = SS_IDLE;
        endcase
        if (!adp || adp_rise) begin
            d.ss = adp ? SS_ON : SS_IDLE;
            d.st_cnt = '0;
            d.tries = '0;
        end

        // safety timer
        lim  = fast_lim(q.ssel);
        if (q.ph == PH_PRE) lim = {2'b00, lim[15:2]};
        run  = q.cen && !q.expired && (q.ph != PH_NONE) && lim != 16'h0_000;
        slow = q.dbl && (dpm || ntc || die_regulation_temperature_hit[q.tsel]) &&
               !(q.ph == PH_PRE || cld);
        d.ph = pre ? PH_PRE : (fst ? PH_FAST : PH_NONE);
        // a dropped charge enable also restarts the count, so re-enable starts fresh
        if (d.ph != q.ph || new_sel || done || !q.cen) begin
            d.safe = '0;
            d.tick = '0;
            d.half = 1'b0;
        end else if (run && !sup) begin
            d.half = slow ? ~q.half : 1'b0;
            if (!slow || q.half) begin
                if (q.tick == 28'(TICK_CYCLES - 1)) begin
                    d.tick = '0;
                    d.safe = q.safe + 16'h0_001;
                    if (q.safe + 16'h0_001 >= lim) begin
                        d.expired = 1'b1;
                        d.ipulse = 13'(INT_PULSE_CYC);
                    end
                end else begin
                    d.tick = q.tick + 28'h000_0001;
                end
            end
        end
        // clearing needs the host to drop charge enable or power to go
        if (!q.cen || !adp) d.expired = 1'b0;
        if (q.ipulse != '0) d.ipulse = q.ipulse - 13'h0001;

        // outputs
        d.in_on  = (q.ss == SS_ON || q.ss == SS_OK) && !q.ovp && !q.hot_lock;
        d.bat_on = !q.hot_lock && (q.ss != SS_LOCK) && !q.ovp;
        d.sys_on = !q.hot_lock;
        d.chg    = q.cen && !q.expired && !q.hot_lock && (q.ss == SS_OK);
        d.red    = die_regulation_temperature_hit[q.tsel];
        d.flag   = d.expired;
        d.ioe    = (d.ipulse != '0);
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            q        <= '0;
            q.ssel   <= SAFETY_SEL_RST;
            q.wsel   <= WD_SEL_RST;
            q.tsel   <= DIE_REGULATION_TEMPERATURE_SEL_RST;
            q.dbl    <= DOUBLE_RST;
            q.cen    <= CHG_EN_RST;
            q.wen    <= 1'b1;
            q.ss     <= SS_IDLE;
            q.ph     <= PH_NONE;
        end else begin
            q <= d;
        end
    end

    assign input_fet_on              = q.in_on;
    assign battery_path_switch_on    = q.bat_on;
    assign sys_enable                = q.sys_on;
    assign charge_allow              = q.chg;
    assign current_reduce            = q.red;
    assign charge_timeout_fault_flag = q.flag;
    assign int_n_oe                  = q.ioe;
    assign wd_reset_pulse            = q.wd_rst;
    assign safety_sel                = q.ssel;
    assign wd_sel                    = q.wsel;
    assign die_regulation_temperature_sel                  = q.tsel;
    assign timeout_doubling_enable   = q.dbl;
    assign chg_en                    = q.cen;
    assign wd_en                     = q.wen;

    // assertions
    property p_short_lock;
        @(posedge clk) disable iff (!rstn) q.ss == SS_LOCK |-> ##1 !input_fet_on;
    endproperty
    a_short_lock: assert property (p_short_lock) else $error("lock drives input on");
    property p_hot;
        @(posedge clk) disable iff (!rstn)
        q.hot_lock |=> !battery_path_switch_on && !input_fet_on;
    endproperty
    a_hot: assert property (p_hot) else $error("hot with FET on");
    property p_ovp;
        @(posedge clk) disable iff (!rstn) q.ovp |=> !input_fet_on;
    endproperty
    a_ovp: assert property (p_ovp) else $error("ovp with FET on");
    property p_exp;
        @(posedge clk) disable iff (!rstn) $rose(q.expired) |-> int_n_oe [*8];
    endproperty
    a_exp: assert property (p_exp) else $error("no int pulse");
    property p_nochg;
        @(posedge clk) disable iff (!rstn) q.expired |=> !charge_allow;
    endproperty
    a_nochg: assert property (p_nochg) else $error("charge after expiry");
    property p_sup;
        @(posedge clk) disable iff (!rstn)
        sup && q.cen && q.ph == $past(q.ph) && q.ph == d.ph && !new_sel && !done
        |=> $stable(q.safe);
    endproperty
    a_sup: assert property (p_sup) else $error("timer moved in supplement");
    property p_wd;
        @(posedge clk) disable iff (!rstn) wd_reset_pulse |-> chg_en && wd_en;
    endproperty
    a_wd: assert property (p_wd) else $error("defaults not restored");
    property p_sys;
        @(posedge clk) disable iff (!rstn) q.hot_lock |=> !sys_enable;
    endproperty
    a_sys: assert property (p_sys) else $error("sys on while hot");
endmodule : cpt_top

/* cpt_host_model.sv */
/*
 * Host stand-in on the serial link: makes the link clock and reset,
 * issues transactions and settings writes to the protection timers.
 * Assumes the bench calls write and ping one at a time.
 */
`timescale 1ns/1ps
module cpt_host_model (
    // link clock, reset and strobes
    output logic       link_clk,
    output logic       link_rstn,
    output logic       link_xact,
    output logic       set_we,
    // settings fields
    output logic [1:0] set_safety_sel,
    output logic [1:0] set_wd_sel,
    output logic [1:0] set_die_regulation_temperature_sel,
    output logic       set_double,
    output logic       set_chg_en,
    output logic       set_wd_en
);
    // the link clock only runs inside a frame and rests low in between
    task automatic tick(input int n);
        repeat (n) begin
            #24 link_clk = 1'b1;
            #24 link_clk = 1'b0;
        end
    endtask : tick

    // one settings write; strobes held over one rising edge, then spaced out
    task automatic write(input logic [1:0] ss, ws, ts, input logic dbl, ce, wde);
        #7;
        {set_safety_sel, set_wd_sel, set_die_regulation_temperature_sel} = {ss, ws, ts};
        {set_double, set_chg_en, set_wd_en} = {dbl, ce, wde};
        set_we = 1'b1;
        link_xact = 1'b1;
        tick(1);
        set_we = 1'b0;
        link_xact = 1'b0;
        tick(3); // three idle link cycles keep events apart
    endtask : write

    // a transaction that carries no settings
    task automatic ping;
        #7;
        link_xact = 1'b1;
        tick(1);
        link_xact = 1'b0;
        tick(3);
    endtask : ping

    // link reset needs edges, so the clock runs during it
    initial begin
        {link_clk, link_rstn, link_xact, set_we} = 4'h0;
        {set_safety_sel, set_wd_sel, set_die_regulation_temperature_sel} = 6'h04;
        {set_double, set_chg_en, set_wd_en} = 3'h7;
        #7;
        tick(3);
        link_rstn = 1'b1;
        tick(2);
    end
endmodule : cpt_host_model

/* cpt_top_tb.sv */
/*
 * Self-checking bench for the charger protection timers.
 * Assumes shortened counts (tick 10, on window 50) and the host model
 * on the link side.
 */
`timescale 1ns/1ps
module cpt_top_tb;
    import cpt_pkg::*;
    localparam int unsigned TICK = 10;
    localparam int unsigned ON   = 50;
    localparam int unsigned WD0  = WD_LIM_0 * TICK;

    logic       clk = 0, rstn = 0, adapter_ok = 0, sys_above_guard = 0;
    logic       sys_below_release = 1, sys_below_short = 0, die_above_shutdown = 0;
    logic       die_below_shutdown_fall = 1, battery_present = 1, in_precharge = 0;
    logic       in_fast = 0, charge_done = 0, dpm_active = 0, ntc_limit = 0;
    logic       battery_cool_region = 0, supplement = 0;
    logic [3:0] die_above_die_regulation_temperature = 4'h0;
    wire        link_clk, link_rstn, link_xact, set_we, set_double, set_chg_en, set_wd_en;
    wire  [1:0] set_safety_sel, set_wd_sel, set_die_regulation_temperature_sel, safety_sel, wd_sel, die_regulation_temperature_sel;
    wire        input_fet_on, battery_path_switch_on, sys_enable, charge_allow;
    wire        current_reduce, charge_timeout_fault_flag, int_n_oe, wd_reset_pulse;
    wire        timeout_doubling_enable, chg_en, wd_en;
    int         n_fail = 0, tests_run = 0;
    int unsigned int_hi = 0, wd_hits = 0, fet_rises = 0, a0, r0;
    logic       fet_prev = 0;
    logic [1:0] sel, rnd;

    cpt_host_model host (.link_clk(link_clk), .link_rstn(link_rstn), .link_xact(link_xact),
        .set_we(set_we), .set_safety_sel(set_safety_sel), .set_wd_sel(set_wd_sel),
        .set_die_regulation_temperature_sel(set_die_regulation_temperature_sel), .set_double(set_double), .set_chg_en(set_chg_en),
        .set_wd_en(set_wd_en));

    cpt_top #(.TICK_CYCLES(TICK), .RETRY_CYCLES(500), .ON_CYCLES(ON)) uut (
        .clk(clk), .rstn(rstn), .link_clk(link_clk), .link_rstn(link_rstn),
        .link_xact(link_xact), .set_we(set_we), .set_safety_sel(set_safety_sel),
        .set_wd_sel(set_wd_sel), .set_die_regulation_temperature_sel(set_die_regulation_temperature_sel), .set_double(set_double),
        .set_chg_en(set_chg_en), .set_wd_en(set_wd_en), .adapter_ok(adapter_ok),
        .sys_above_guard(sys_above_guard), .sys_below_release(sys_below_release),
        .sys_below_short(sys_below_short), .die_above_shutdown(die_above_shutdown),
        .die_below_shutdown_fall(die_below_shutdown_fall), .die_above_die_regulation_temperature(die_above_die_regulation_temperature),
        .battery_present(battery_present), .in_precharge(in_precharge), .in_fast(in_fast),
        .charge_done(charge_done), .dpm_active(dpm_active), .ntc_limit(ntc_limit),
        .battery_cool_region(battery_cool_region), .supplement(supplement),
        .input_fet_on(input_fet_on), .battery_path_switch_on(battery_path_switch_on),
        .sys_enable(sys_enable), .charge_allow(charge_allow), .current_reduce(current_reduce),
        .charge_timeout_fault_flag(charge_timeout_fault_flag), .int_n_oe(int_n_oe),
        .wd_reset_pulse(wd_reset_pulse), .safety_sel(safety_sel), .wd_sel(wd_sel),
        .die_regulation_temperature_sel(die_regulation_temperature_sel), .timeout_doubling_enable(timeout_doubling_enable),
        .chg_en(chg_en), .wd_en(wd_en));

    always #10 clk = ~clk;

    // event counters; tests compare differences so nothing else writes them
    always @(posedge clk) begin
        if (int_n_oe === 1'b1) int_hi <= int_hi + 1;
        if (wd_reset_pulse === 1'b1) wd_hits <= wd_hits + 1;
        if (input_fet_on === 1'b1 && fet_prev !== 1'b1) fet_rises <= fet_rises + 1;
        fet_prev <= input_fet_on;
    end

    // precharge limit in core cycles: a quarter of the fast-charge limit
    function automatic int unsigned pre_cyc(input logic [1:0] s);
        logic [15:0] lim;
        case (s)
            2'h0: lim = FAST_LIM_0;
            2'h1: lim = FAST_LIM_1;
            2'h2: lim = FAST_LIM_2;
            default: lim = FAST_LIM_3;
        endcase
        return (lim / 4) * TICK;
    endfunction : pre_cyc

    task automatic step(input int unsigned n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask : done

    task automatic summarize;
        $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // the whole run should need about 33000 cycles
    initial begin
        step(60000);
        n_fail++;
        summarize();
    end

    initial begin
        void'($urandom(30188));
        step(4);
        rstn <= 1'b1;
        step(3);
        chk(16'({safety_sel, wd_sel, die_regulation_temperature_sel, timeout_doubling_enable, chg_en, wd_en}),
            16'({SAFETY_SEL_RST, WD_SEL_RST, DIE_REGULATION_TEMPERATURE_SEL_RST, DOUBLE_RST, CHG_EN_RST, 1'b1}));
        done("defaults");
        adapter_ok <= 1'b1;
        step(ON + 40);
        chk(16'({input_fet_on, battery_path_switch_on, sys_enable, charge_allow}), 16'h000f);
        done("adapter");
        // hysteresis: falling under the trip level alone must not reclose
        {sys_above_guard, sys_below_release} <= 2'b10;
        step(20);
        chk(16'(input_fet_on), 16'h0000);
        sys_above_guard <= 1'b0;
        step(20);
        chk(16'(input_fet_on), 16'h0000);
        sys_below_release <= 1'b1;
        step(20);
        chk(16'(input_fet_on), 16'h0001);
        done("overvoltage");
        // power applied while the die is already hot
        {adapter_ok, die_above_shutdown, die_below_shutdown_fall} <= 3'b010;
        step(20);
        adapter_ok <= 1'b1;
        step(ON + 40);
        chk(16'({input_fet_on, battery_path_switch_on, sys_enable, charge_allow}), 16'h0000);
        {die_above_shutdown, die_below_shutdown_fall} <= 2'b01;
        step(ON + 40);
        chk(16'({input_fet_on, sys_enable, charge_allow}), 16'h0007);
        done("thermal");
        rnd = 2'($urandom_range(3));
        for (int k = 0; k < 4; k++) begin
            sel = 2'(k) ^ rnd;
            host.write(SAFETY_SEL_RST, 2'h3, sel, 1'b1, 1'b1, 1'b0);
            step(10);
            chk(16'(die_regulation_temperature_sel), 16'(sel));
            {dpm_active, ntc_limit} <= 2'($urandom_range(3));
            die_above_die_regulation_temperature <= 4'h1 << sel;
            step(10);
            chk(16'({current_reduce, battery_path_switch_on}), 16'h0003);
            die_above_die_regulation_temperature <= ~(4'h1 << sel);
            step(10);
            chk(16'(current_reduce), 16'h0000);
        end
        {dpm_active, ntc_limit, die_above_die_regulation_temperature} <= 6'h00;
        done("regulation");
        // precharge in the cool region with doubling on, duration rewritten mid-run
        {in_precharge, battery_cool_region} <= 2'b11;
        step(3000);
        host.write(2'h0, 2'h3, 2'h0, 1'b1, 1'b1, 1'b0);
        step(1000);
        supplement <= 1'b1;
        step(2000);
        supplement <= 1'b0;
        a0 = int_hi;
        step(pre_cyc(2'h0) - 1200);
        chk(16'(charge_timeout_fault_flag), 16'h0000);
        step(400);
        chk(16'({charge_timeout_fault_flag, charge_allow}), 16'h0002);
        step(INT_PULSE_CYC);
        chk(16'(int_hi - a0), 16'(INT_PULSE_CYC));
        host.write(2'h0, 2'h3, 2'h0, 1'b1, 1'b0, 1'b0);
        host.write(2'h0, 2'h3, 2'h0, 1'b1, 1'b1, 1'b0);
        step(10);
        chk(16'({charge_timeout_fault_flag, charge_allow}), 16'h0001);
        {in_precharge, battery_cool_region} <= 2'b00;
        done("safety");
        // shorted rail: first window fails, then off and one retry window
        {sys_below_short, adapter_ok} <= 2'b10;
        step(20);
        r0 = fet_rises;
        adapter_ok <= 1'b1;
        step(ON + 2000);
        chk(16'({input_fet_on, battery_path_switch_on}), 16'h0001);
        step(FET_OFF_CYC - 1800);
        chk(16'(fet_rises - r0), 16'h0002);
        sys_below_short <= 1'b0;
        done("short");
        host.write(SAFETY_SEL_RST, 2'h0, 2'h2, 1'b1, 1'b1, 1'b1);
        a0 = wd_hits;
        repeat (3) begin
            step(WD0 - 150);
            host.ping();
        end
        chk(16'({wd_hits - a0, die_regulation_temperature_sel}), 16'h0002);
        step(WD0 + 100);
        chk(16'({wd_hits - a0, die_regulation_temperature_sel}), 16'({1'b1, DIE_REGULATION_TEMPERATURE_SEL_RST}));
        done("watchdog");
        summarize();
    end
endmodule : cpt_top_tb
